// >>> bench/ascd_adc_model.sv
// Behavioural ADC core facing the conversion start port.
// Assumes the bench sets the conversion delay (1 or more cycles).
`timescale 1ns/1ps

module ascd_adc_model
(
    input  wire        i_clk,
    input  wire [7:0]  adc_delay,
    input  wire        o_conv_start,
    input  wire [3:0]  o_conv_chan,
    output reg         i_conv_done,
    output reg  [11:0] i_conv_result
);
    reg [7:0] cnt_reg = 8'h00; // Cycles left in the running conversion.

    initial i_conv_done = 1'b0;
    initial i_conv_result = 12'h000;

    // Result lines toggle when not valid so stale data never looks right.
    always @(posedge i_clk)
    begin
        i_conv_done <= 1'b0;
        i_conv_result <= ~i_conv_result;
        if (o_conv_start)
            cnt_reg <= adc_delay;
        else if (cnt_reg != 8'h00)
        begin
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01)
            begin
                i_conv_done <= 1'b1;
                i_conv_result <= {o_conv_chan, 8'h3c};
            end
        end
    end
endmodule

// >>> bench/ascd_props.sv
// Checker for the scan and shutdown command block.
// Sees only the top ports; bound from the bench top.
`timescale 1ns/1ps

module ascd_props
(
    input wire        i_clk,
    input wire        i_rst_n,
    input wire        i_cmd_valid,
    input wire [7:0]  i_cmd,
    input wire [15:0] i_data,
    input wire        i_result_fifo_load_enable,
    input wire        i_conv_done,
    input wire [11:0] i_conv_result,
    input wire        o_conv_start,
    input wire [3:0]  o_conv_chan,
    input wire        o_fifo_push,
    input wire [15:0] o_fifo_data,
    input wire        o_busy,
    input wire        o_ref_on,
    input wire        o_temp_sensor_on,
    input wire        o_adc_enable,
    input wire        o_full_power_down,
    input wire        o_bandgap_force_on,
    input wire        o_watchdog_osc_off,
    input wire        o_internal_osc_off,
    input wire [3:0]  o_ch2_off,
    input wire [3:0]  o_ch1_off
);
    // ********
    // Helpers
    // ********
    reg  cont_reg; // Last written continuous bit; without it, low busy means the sequencer is idle.
    wire shut_wr = i_cmd_valid && (i_cmd == 8'h64);
    wire conv_wr = i_cmd_valid && (i_cmd == 8'h62);

    // Tracks the continuous bit so start latency is judged from true idle only.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
            cont_reg <= 1'b0;
        else if (conv_wr)
            cont_reg <= i_data[11];
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // A single scan raises busy first, then launches the first conversion.
    sequence s_scan_go;
        o_busy ##1 o_conv_start;
    endsequence

    // ********
    // Assertions
    // ********
    AST_SHUT_WR: assert property (shut_wr |-> ##2 o_full_power_down == $past(i_data[11], 2)
        && {o_ch2_off, o_ch1_off} == ($past(i_data[11], 2) ? 8'hff : $past(i_data[7:0], 2)))
        else $error("shutdown write not reflected");
    AST_BANDGAP: assert property (shut_wr && !i_data[11]
        |-> ##2 o_bandgap_force_on == $past(i_data[10], 2)
        && o_watchdog_osc_off == $past(i_data[9], 2))
        else $error("bandgap or watchdog bit wrong");
    AST_OSC_CLR: assert property (i_cmd_valid && i_cmd != 8'h64
        |-> ##2 (!o_internal_osc_off || o_full_power_down))
        else $error("oscillator off not cleared");
    AST_ADC_EN: assert property (o_adc_enable == !o_full_power_down)
        else $error("adc enable disagrees with full power down");
    AST_SCAN_GO: assert property (conv_wr && !i_data[11] && i_data[10:0] != 11'h000
        && !o_busy && !cont_reg && !o_full_power_down |=> s_scan_go)
        else $error("scan did not start");
    AST_PUSH_SRC: assert property (o_fifo_push |-> $past(i_conv_done)
        && $past(i_result_fifo_load_enable) && o_fifo_data == {o_conv_chan, $past(i_conv_result)})
        else $error("push without source");
    AST_NO_PUSH: assert property (i_conv_done && !i_result_fifo_load_enable |=> !o_fifo_push)
        else $error("push while monitor off");
    AST_FPD_HOLD: assert property (o_full_power_down && $past(o_full_power_down)
        |-> !o_conv_start && !o_busy)
        else $error("activity in full power down");
    AST_REF_ON: assert property (o_conv_start |-> o_ref_on && (o_temp_sensor_on
        || !(o_conv_chan == 4'h0 || o_conv_chan == 4'h1 || o_conv_chan == 4'h6)))
        else $error("reference or sensor off at start");
    AST_RESET: assert property (disable iff (1'b0) !i_rst_n |=> o_full_power_down
        && o_ch1_off == 4'hf && o_ch2_off == 4'hf && !o_busy)
        else $error("reset state wrong");
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the scan and shutdown command block.
// Assumes the ADC model answers each start after adc_delay cycles.
`timescale 1ns/1ps

module tb_top;
    logic        i_clk, i_rst_n, i_cmd_valid, i_result_fifo_load_enable;
    logic        i_clock_select_hi, i_clock_select_lo;
    logic [7:0]  i_cmd, adc_delay;
    logic [15:0] i_data;
    wire         i_conv_done, o_conv_start, o_fifo_push, o_busy, o_ref_on, o_adc_enable;
    wire         o_temp_sensor_on, o_full_power_down, o_bandgap_force_on;
    wire         o_watchdog_osc_off, o_internal_osc_off;
    wire [11:0]  i_conv_result;
    wire [3:0]   o_conv_chan, o_ch2_off, o_ch1_off;
    wire [15:0]  o_fifo_data;
    int          errors = 0, check_count = 0, pushes = 0, i;
    logic [3:0]  q[$]; // Channels launched, in order.
    logic        busy_seen;
    wire  [11:0] pwr = {o_full_power_down, o_bandgap_force_on, o_watchdog_osc_off,
                        o_internal_osc_off, o_ch2_off, o_ch1_off};
    // Shutdown rows: data written and power outputs expected.
    logic [15:0] shut_in  [7] = '{16'hf000, 16'h0400, 16'h0200, 16'h0100,
                                  16'h00a5, 16'h085a, 16'h0000};
    logic [11:0] shut_exp [7] = '{12'h000, 12'h400, 12'h200, 12'h100,
                                  12'h0a5, 12'hbff, 12'h000};

    ascd_top       ascd_top_i (.*);
    ascd_adc_model ascd_adc_model_i (.*);

    // ********
    // Clock, monitor and watchdog
    // ********
    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // Sampled at the edge, so values seen are those that stood for the cycle.
    always @(posedge i_clk)
    begin
        if (o_conv_start) q.push_back(o_conv_chan);
        if (o_fifo_push) pushes++;
        if (o_busy) busy_seen = 1'b1;
    end

    // The whole run needs a few hundred cycles; this allows 20000 cycles.
    initial
    begin
        #80000;
        errors++;
        report_and_stop();
    end

    // ********
    // Tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    // Issues one command; outputs of the taking edge are settled on return.
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge i_clk);
        #1 i_cmd_valid = 1'b1;
        i_cmd = c;
        i_data = d;
        @(posedge i_clk);
        #1 i_cmd_valid = 1'b0;
    endtask

    // Clears the monitor record.
    task automatic clr();
        q.delete();
        pushes = 0;
        busy_seen = 1'b0;
    endtask

    // Waits, bounded, until busy drops.
    task automatic wait_idle();
        repeat (2) @(posedge i_clk);
        for (i = 0; i < 500 && o_busy !== 1'b0; i++) @(posedge i_clk);
        #1 chk(o_busy, 0, "busy stuck");
    endtask

    task automatic report_and_stop();
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ********
    // Main sequence
    // ********
    initial
    begin
        {i_rst_n, i_cmd_valid, i_clock_select_hi, i_clock_select_lo} = 4'h0;
        {i_cmd, i_data} = 24'h00_0000;
        i_result_fifo_load_enable = 1'b1;
        adc_delay = 8'h03;
        clr();
        repeat (10) @(posedge i_clk);
        #1 chk(pwr, 12'h8ff, "reset power state");
        i_rst_n = 1'b1;
        // Power outputs follow the register one cycle after the taking edge.
        for (int r = 0; r < 7; r++)
        begin
            wr(8'h64, shut_in[r]);
            @(posedge i_clk);
            #1 chk(pwr, shut_exp[r], "shutdown row");
        end
        wr(8'h64, 16'h0100);
        @(posedge i_clk);
        #1 chk(o_internal_osc_off, 1, "osc off not set");
        wr(8'h66, 16'h0000);
        @(posedge i_clk);
        #1 chk(o_internal_osc_off, 0, "osc off kept");
        // Single scan, top nibble junk, monitor off, empty mask.
        clr();
        wr(8'h62, 16'hf445);
        wait_idle();
        chk({16'(q.size()), q[0], q[1], q[2], q[3]}, {16'h4, 16'h026a}, "scan order");
        chk(pushes, 4, "push count");
        clr();
        i_result_fifo_load_enable = 1'b0;
        wr(8'h62, 16'h0001);
        wait_idle();
        chk({16'(q.size()), 16'(pushes)}, {16'h1, 16'h0}, "monitor off");
        i_result_fifo_load_enable = 1'b1;
        clr();
        wr(8'h62, 16'h0000);
        repeat (8) @(posedge i_clk);
        chk(q.size(), 0, "empty mask started");
        // Continuous scan then stop.
        wr(8'h62, 16'h0843);
        repeat (60) @(posedge i_clk);
        #1 chk(busy_seen, 0, "busy in continuous");
        chk(q.size() > 5, 1, "no repeat scans");
        chk({o_ref_on, o_temp_sensor_on}, 2'b11, "reference off");
        wr(8'h62, 16'h0043);
        @(posedge i_clk);
        #1 chk(o_busy, 1, "busy after stop");
        wait_idle();
        chk(q[$], 6, "scan cut short");
        i = q.size();
        repeat (20) @(posedge i_clk);
        chk(q.size(), i, "started after stop");
        // Continuous bit outside modes 00/01 gives one scan.
        i_clock_select_hi = 1'b1;
        repeat (8) @(posedge i_clk);
        clr();
        wr(8'h62, 16'h0801);
        // Busy stays low here, so wait out the whole scan before counting.
        repeat (18) @(posedge i_clk);
        wait_idle();
        chk(q.size(), 1, "mode 10 scan");
        i_clock_select_hi = 1'b0;
        // Full power-down in mid scan.
        adc_delay = 8'h28;
        clr();
        wr(8'h62, 16'h07ff);
        repeat (6) @(posedge i_clk);
        wr(8'h64, 16'h0800);
        repeat (100) @(posedge i_clk);
        chk({o_busy, o_adc_enable, 16'(q.size())}, 18'h1, "scan not killed");
        report_and_stop();
    end
endmodule

bind ascd_top ascd_props ascd_props_i (.*);

// >>> design/ascd_defines.vh
// Constants for the ADC scan and shutdown command block.
// Assumes the serial front end delivers a command byte with a 16-bit data word.
`ifndef ASCD_DEFINES_VH
`define ASCD_DEFINES_VH

// ****************************************************************
// Command codes
// ****************************************************************
`define ASCD_CMD_ADC_CONV      8'h62
`define ASCD_CMD_SHUTDOWN      8'h64

// ****************************************************************
// Conversion register fields
// ****************************************************************
`define ASCD_CONV_CONT_BIT     11
`define ASCD_NUM_CH            11
`define ASCD_CONV_RESET        12'h000
`define ASCD_TEMP_CH_MASK      11'h043
`define ASCD_INTREF_CH_MASK    11'h7ff

// ****************************************************************
// Shutdown register fields
// ****************************************************************
`define ASCD_SHUT_FULL_POWER_DOWN_BIT   11
`define ASCD_SHUT_BANDGAP_BIT  10
`define ASCD_SHUT_WDOG_BIT     9
`define ASCD_SHUT_OSC_BIT      8
`define ASCD_SHUT_RESET        12'h8ff

// ****************************************************************
// Clock modes that allow continuous conversion
// ****************************************************************
`define ASCD_CKMODE_00         2'b00
`define ASCD_CKMODE_01         2'b01

`endif

// >>> design/ascd_scan_pick.v
// Picks the lowest selected channel at or above a start position.
// Pure combinational; used by the scan sequencer to walk in ascending order.
`timescale 1ns/1ps

module ascd_scan_pick
(
    input  wire [10:0] i_mask,
    input  wire [3:0]  i_from,
    output reg         o_found,
    output reg  [3:0]  o_chan
);

    integer k; // Loop index.

    // Scan downward so the lowest qualifying index is kept last.
    always @*
    begin
        o_found = 1'b0;
        o_chan  = 4'h0;
        for (k = 10; k >= 0; k = k - 1)
        begin
            if (i_mask[k] && (k >= i_from))
            begin
                o_found = 1'b1;
                o_chan  = k[3:0];
            end
        end
    end

endmodule

// >>> design/ascd_sync3.v
// Three-stage input synchroniser for a level from outside the clock domain.
// Assumes one clock; a change is accepted once stages two and three agree.
`timescale 1ns/1ps

module ascd_sync3
(
    input  wire i_clk,
    input  wire i_rst_n,
    input  wire i_async,
    output reg  o_level
);

    reg [2:0] stage_reg; // Stage 0 is read only by stage 1.

    // Shift in, then update the output when the last two stages agree.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            stage_reg <= 3'b000;
            o_level   <= 1'b0;
        end
        else
        begin
            stage_reg <= {stage_reg[1:0], i_async};
            if (stage_reg[1] == stage_reg[2])
            begin
                o_level <= stage_reg[2];
            end
        end
    end

endmodule

// >>> design/ascd_top.v
// Command register logic for ADC scanning and power shutdown control.
// Assumes a serial front end presents i_cmd/i_data with a one-cycle i_cmd_valid,
// and an ADC core that takes o_conv_start and answers with i_conv_done.
`timescale 1ns/1ps
`include "ascd_defines.vh"

// Operation
// R1: Command 62h writes conversion register.
// R2: Conversion data bits 15..12 ignored.
// R3: FIFO load only when monitor enabled.
// R4: Continuous bit repeats scans per clock mode.
// R5: Eleven select bits, one per channel.
// R6: Selected channels convert in ascending order.
// R7: Continuous only in clock modes 00/01.
// R8: No busy during continuous conversions.
// R9: Temperature scan keeps sensor and reference on.
// R10: Reference on before first continuous conversion.
// R11: Clearing continuous finishes current scan first.
// R12: Busy high from clear until scan ends.
// R13: Results accumulate; host must drain FIFO.
// R14: Host clears sense power-down before gate conversion.
// R15: Command 64h writes shutdown, bits 15..12 ignored.
// R16: Full power-down bit 11, set at reset.
// R17: Host clears full power-down first.
// R18: Bit 10 keeps bandgap powered.
// R19: Bit 9 stops watchdog oscillator.
// R20: Bit 8 powers down internal oscillator.
// R21: Bits 7..4 power down channel 2 parts.
// R22: Bits 3..0 power down channel 1 parts.
// R23: Oscillator-off clears on next command.
// R24: Full power-down overrides all, suspends scans.
// R25: Non-continuous write with channels starts one scan.
module ascd_top
(
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_cmd_valid,
    input  wire [7:0]  i_cmd,
    input  wire [15:0] i_data,
    input  wire        i_result_fifo_load_enable,
    input  wire        i_clock_select_hi,
    input  wire        i_clock_select_lo,
    input  wire        i_conv_done,
    input  wire [11:0] i_conv_result,
    output reg         o_conv_start,
    output reg  [3:0]  o_conv_chan,
    output reg         o_fifo_push,
    output reg  [15:0] o_fifo_data,
    output reg         o_busy,
    output reg         o_ref_on,
    output reg         o_temp_sensor_on,
    output reg         o_adc_enable,
    output reg         o_full_power_down,
    output reg         o_bandgap_force_on,
    output reg         o_watchdog_osc_off,
    output reg         o_internal_osc_off,
    output reg  [3:0]  o_ch2_off,
    output reg  [3:0]  o_ch1_off
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam [1:0] ST_IDLE = 2'b00; // Waiting for a command.
    localparam [1:0] ST_PICK = 2'b01; // Finding the next channel.
    localparam [1:0] ST_CONV = 2'b10; // Waiting for a conversion.

    reg  [11:0] conv_reg;             // Continuous bit and channel selects.
    reg  [11:0] shut_reg;             // Shutdown bits.
    reg  [1:0]  state_reg;            // Scan sequencer state.
    reg  [1:0]  state_next;
    reg  [3:0]  pos_reg;              // Next channel index to search from.
    reg  [3:0]  pos_next;
    reg  [10:0] scan_mask_reg;        // Channels of the scan in progress.
    reg  [10:0] scan_mask_next;
    reg         stopping_reg;         // Continuous cleared, scan draining.
    reg         stopping_next;
    wire        pick_found;           // A channel remains in this scan.
    wire [3:0]  pick_chan;            // That channel's index.
    wire        ck_hi_s;              // Synchronised clock-select bits.
    wire        ck_lo_s;
    wire        conv_wr;              // Write strobe for the conversion register.
    wire        shut_wr;              // Write strobe for the shutdown register.
    wire        cont_ok;              // Continuous mode is legal now.
    wire        cont_eff;             // Continuous bit as it stands after this edge.

    assign conv_wr = i_cmd_valid && (i_cmd == `ASCD_CMD_ADC_CONV); // R1
    assign shut_wr = i_cmd_valid && (i_cmd == `ASCD_CMD_SHUTDOWN); // R15
    assign cont_ok = conv_reg[`ASCD_CONV_CONT_BIT]
                     && (({ck_hi_s, ck_lo_s} == `ASCD_CKMODE_00)
                     ||  ({ck_hi_s, ck_lo_s} == `ASCD_CKMODE_01)); // R7
    // Busy must follow the bit being written now, or a continuous start from
    // idle would flash busy for one cycle.
    assign cont_eff = conv_wr ? i_data[`ASCD_CONV_CONT_BIT]
                              : conv_reg[`ASCD_CONV_CONT_BIT];

    // ****************************************************************
    // Sub-blocks
    // ****************************************************************
    // Clock-select bits come from another register group, so treat as async.
    ascd_sync3 u_sync_hi
    (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_clock_select_hi),
        .o_level (ck_hi_s)
    );

    ascd_sync3 u_sync_lo
    (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_clock_select_lo),
        .o_level (ck_lo_s)
    );

    // The picker always searches the latched scan mask, not the live register,
    // so a rewrite mid-scan cannot reorder or skip channels.
    ascd_scan_pick u_pick
    (
        .i_mask  (scan_mask_reg),
        .i_from  (pos_reg),
        .o_found (pick_found),
        .o_chan  (pick_chan)
    );

    // ****************************************************************
    // Command registers
    // ****************************************************************
    // Store the low twelve bits of each write; the top four are dropped.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            conv_reg <= `ASCD_CONV_RESET;
            shut_reg <= `ASCD_SHUT_RESET; // R16
        end
        else
        begin
            if (conv_wr)
            begin
                conv_reg <= i_data[11:0]; // R2
            end
            if (shut_wr)
            begin
                shut_reg <= i_data[11:0]; // R15
            end
            else if (i_cmd_valid)
            begin
                // Any other command ends the oscillator power-down.
                shut_reg[`ASCD_SHUT_OSC_BIT] <= 1'b0; // R23
            end
        end
    end

    // ****************************************************************
    // Scan sequencer, next state
    // ****************************************************************
    // Walks selected channels low to high; repeats while continuous holds.
    always @*
    begin
        state_next     = state_reg;
        pos_next       = pos_reg;
        scan_mask_next = scan_mask_reg;
        stopping_next  = stopping_reg;
        case (state_reg)
            ST_IDLE:
            begin
                stopping_next = 1'b0;
                // A new write with channels starts a scan, single or looping.
                if (conv_wr && (i_data[10:0] != 11'h000)) // R25
                begin
                    scan_mask_next = i_data[10:0]; // R5
                    pos_next       = 4'h0;
                    state_next     = ST_PICK;
                end
            end
            ST_PICK:
            begin
                if (pick_found)
                begin
                    state_next = ST_CONV;
                end
                else if (cont_ok && !stopping_reg) // R4
                begin
                    // Restart from channel 0 with the latest selection.
                    scan_mask_next = conv_reg[10:0];
                    pos_next       = 4'h0;
                    if (conv_reg[10:0] == 11'h000)
                    begin
                        state_next = ST_IDLE;
                    end
                end
                else
                begin
                    state_next = ST_IDLE; // R11
                end
            end
            ST_CONV:
            begin
                if (i_conv_done)
                begin
                    pos_next   = o_conv_chan + 4'h1; // R6
                    state_next = ST_PICK;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        // Clearing continuous mid-scan marks the remaining scan as draining.
        if ((state_reg != ST_IDLE) && !conv_reg[`ASCD_CONV_CONT_BIT])
        begin
            stopping_next = 1'b1; // R11
        end
        // Full power-down abandons any scan at once.
        if (shut_reg[`ASCD_SHUT_FULL_POWER_DOWN_BIT]) // R24
        begin
            state_next    = ST_IDLE;
            stopping_next = 1'b0;
        end
    end

    // ****************************************************************
    // Scan sequencer, registers and strobes
    // ****************************************************************
    // Issues one start pulse per channel and forwards each result while monitoring is on.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_reg     <= ST_IDLE;
            pos_reg       <= 4'h0;
            scan_mask_reg <= 11'h000;
            stopping_reg  <= 1'b0;
            o_conv_start  <= 1'b0;
            o_conv_chan   <= 4'h0;
            o_fifo_push   <= 1'b0;
            o_fifo_data   <= 16'h0000;
        end
        else
        begin
            state_reg     <= state_next;
            pos_reg       <= pos_next;
            scan_mask_reg <= scan_mask_next;
            stopping_reg  <= stopping_next;
            o_conv_start  <= 1'b0;
            o_fifo_push   <= 1'b0;
            if ((state_reg == ST_PICK) && (state_next == ST_CONV))
            begin
                o_conv_start <= 1'b1;
                o_conv_chan  <= pick_chan; // R6
            end
            // Results go to the FIFO only with monitoring on; overflow is the
            // host's concern, since no readout path is visible here.
            if ((state_reg == ST_CONV) && i_conv_done && i_result_fifo_load_enable) // R3
            begin
                o_fifo_push <= 1'b1; // R13
                o_fifo_data <= {o_conv_chan, i_conv_result};
            end
        end
    end

    // ****************************************************************
    // Busy, reference and power outputs
    // ****************************************************************
    // Busy shows only scans written without the continuous bit and the drain after continuous is cleared.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_busy             <= 1'b0;
            o_ref_on           <= 1'b0;
            o_temp_sensor_on   <= 1'b0;
            o_adc_enable       <= 1'b0;
            o_full_power_down  <= 1'b1;
            o_bandgap_force_on <= 1'b0;
            o_watchdog_osc_off <= 1'b0;
            o_internal_osc_off <= 1'b0;
            o_ch2_off          <= 4'hf;
            o_ch1_off          <= 4'hf;
        end
        else
        begin
            o_busy <= (state_next != ST_IDLE)
                      && (!cont_eff || stopping_next); // R8 R12
            // Reference rises with the first pick, ahead of the start pulse.
            o_ref_on <= !shut_reg[`ASCD_SHUT_FULL_POWER_DOWN_BIT]
                        && (shut_reg[`ASCD_SHUT_BANDGAP_BIT] // R18
                        || ((state_next != ST_IDLE)
                        && ((scan_mask_next & `ASCD_INTREF_CH_MASK) != 11'h000))); // R10 R9
            o_temp_sensor_on <= !shut_reg[`ASCD_SHUT_FULL_POWER_DOWN_BIT] && (state_next != ST_IDLE)
                        && ((scan_mask_next & `ASCD_TEMP_CH_MASK) != 11'h000); // R9
            o_adc_enable       <= !shut_reg[`ASCD_SHUT_FULL_POWER_DOWN_BIT]; // R24
            o_full_power_down  <= shut_reg[`ASCD_SHUT_FULL_POWER_DOWN_BIT]; // R16
            o_bandgap_force_on <= shut_reg[`ASCD_SHUT_BANDGAP_BIT]
                                  && !shut_reg[`ASCD_SHUT_FULL_POWER_DOWN_BIT]; // R18
            o_watchdog_osc_off <= shut_reg[`ASCD_SHUT_WDOG_BIT]
                                  || shut_reg[`ASCD_SHUT_FULL_POWER_DOWN_BIT]; // R19
            o_internal_osc_off <= shut_reg[`ASCD_SHUT_OSC_BIT]
                                  || shut_reg[`ASCD_SHUT_FULL_POWER_DOWN_BIT]; // R20
            o_ch2_off <= shut_reg[7:4] | {4{shut_reg[`ASCD_SHUT_FULL_POWER_DOWN_BIT]}}; // R21
            o_ch1_off <= shut_reg[3:0] | {4{shut_reg[`ASCD_SHUT_FULL_POWER_DOWN_BIT]}}; // R22
        end
    end

endmodule
